// [rhpsb_cmd_decode.sv]
// Command and event decoder for the port state bits
`timescale 1ns/1ps
`default_nettype none
module rhpsb_cmd_decode
    import rhpsb_pkg::*;
(
    input wire logic wr_strobe,
    input wire logic [rhpsb_pkg::RHPSB_CMD_W-1:0] wr_data,
    input wire logic line_connected,
    input wire logic fixed_device,
    input wire logic overcurrent,
    input wire logic power_off,
    input wire logic babble,
    input wire logic enabled_now,
    rhpsb_if.src ev
);
    logic attach_live;
    logic want_suspend;
    logic want_enable;

    // ==========================================
    // Attach and command qualification
    assign attach_live = line_connected | fixed_device; // R10 R13
    assign want_suspend = wr_strobe & wr_data[RHPSB_BIT_SUSPEND];
    assign want_enable = wr_strobe & wr_data[RHPSB_BIT_ENABLE];
    assign ev.attach = attach_live;
    // Suspend and enable commands to a detached port only flag the attach change
    assign ev.set_suspend = want_suspend & attach_live; // R01 R02
    assign ev.set_enable = want_enable & attach_live; // R08 R09 R06
    assign ev.attach_change_pulse = (want_suspend | want_enable) & ~attach_live; // R02 R09
    assign ev.clr_enable = wr_strobe & wr_data[RHPSB_BIT_DISABLE]; // R11
    // Hardware disable causes, counted only while enabled so change flag is honest
    assign ev.hw_disable = enabled_now & (overcurrent | power_off | babble | ~attach_live); // R04
endmodule : rhpsb_cmd_decode
`default_nettype wire

// [rhpsb_dev_model.sv]
// Attached device model: drives the live downstream connect line
`timescale 1ns/1ps
`default_nettype none
module rhpsb_dev_model (
    input wire logic mclk,
    input wire logic plug,
    output logic line_connected
);
    // Line moves just after an edge, never on it
    initial line_connected = 1'b0;
    always @(posedge mclk) line_connected <= #1 plug;
endmodule : rhpsb_dev_model
`default_nettype wire

// [rhpsb_if.sv]
// Interface carrying decoded port events from the event decoder to the port core
`timescale 1ns/1ps
`default_nettype none
interface rhpsb_if;
    logic set_enable;
    logic clr_enable;
    logic set_suspend;
    logic hw_disable;
    logic attach;
    logic attach_change_pulse;
    modport src (output set_enable, output clr_enable, output set_suspend, output hw_disable,
                 output attach, output attach_change_pulse);
    modport dst (input set_enable, input clr_enable, input set_suspend, input hw_disable,
                 input attach, input attach_change_pulse);
endinterface : rhpsb_if
`default_nettype wire

// [rhpsb_pkg.sv]
// Package for the root hub port state bits block
package rhpsb_pkg;
    // ==========================================
    // Write-command bit positions in the port word
    localparam int unsigned RHPSB_BIT_DISABLE = 0;
    localparam int unsigned RHPSB_BIT_ENABLE = 1;
    localparam int unsigned RHPSB_BIT_SUSPEND = 2;
    localparam int unsigned RHPSB_CMD_W = 3;
    // ==========================================
    // Reset values
    localparam logic RHPSB_RST_ENABLED = 1'b0;
    localparam logic RHPSB_RST_SUSPENDED = 1'b0;
    localparam logic RHPSB_RST_ATTACH = 1'b0;

    // Suspend sub-state of the port
    typedef enum logic [1:0] {
        RHPSB_ACTIVE,
        RHPSB_SUSPENDED,
        RHPSB_RESUMING
    } rhpsb_susp_t;
endpackage : rhpsb_pkg

// [rhpsb_port.sv]
// Top of the root hub port state bits: suspend, enable and attach flags
`timescale 1ns/1ps
`default_nettype none
// Function
// R01: Write one suspends an attached port
// R02: Suspend while detached sets attach change
// R03: Suspended flag high while suspended or resuming
// R04: Hardware may disable on fault or detach
// R05: Hardware disable also sets enable change
// R06: Enabled never set while detached
// R07: Reset completion sets enabled flag
// R08: Write one enables; zero ignored
// R09: Enable while detached sets attach change
// R10: Attach flag follows live connection
// R11: Write one at bit zero disables
// R12: Writes never change attach flag
// R13: Fixed device always reads attached
// R14: Suspend clears at resume end, reset, controller resume
// R15: Reset clears flags, attach from line
module rhpsb_port
    import rhpsb_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic wr_strobe,
    input wire logic [rhpsb_pkg::RHPSB_CMD_W-1:0] wr_data,
    input wire logic line_connected,
    input wire logic fixed_device,
    input wire logic overcurrent,
    input wire logic power_off,
    input wire logic babble,
    input wire logic resume_start,
    input wire logic resume_done,
    input wire logic port_reset_done,
    input wire logic hc_resume_state,
    output logic port_suspended_flag,
    output logic port_enabled_flag,
    output logic attach_flag,
    output logic attach_change_flag,
    output logic enable_change_flag,
    output logic reset_done_change_flag,
    output logic suspend_change_flag
);
    // Whole port state as one word: one comb fills it, one flop holds it
    typedef struct packed {
        rhpsb_susp_t susp;
        logic suspended;
        logic enabled;
        logic attach;
        logic attach_chg;
        logic enable_chg;
        logic reset_chg;
        logic suspend_chg;
    } rhpsb_state_t;

    // ==========================================
    // Next-state helpers
    // Suspended or resuming both read as suspended
    function automatic logic rhpsb_is_suspended(input rhpsb_susp_t s);
        return (s != RHPSB_ACTIVE);
    endfunction : rhpsb_is_suspended

    // State loaded while reset is held; attach still follows the line
    function automatic rhpsb_state_t rhpsb_reset_state(input logic attach_now);
        rhpsb_state_t s;
        s.susp = RHPSB_ACTIVE;
        s.suspended = RHPSB_RST_SUSPENDED;
        s.enabled = RHPSB_RST_ENABLED;
        s.attach = attach_now; // R15
        s.attach_chg = 1'b0;
        s.enable_chg = 1'b0;
        s.reset_chg = 1'b0;
        s.suspend_chg = 1'b0;
        return s;
    endfunction : rhpsb_reset_state

    // Suspend sub-state step; a repeated suspend command while suspended is ignored
    function automatic rhpsb_susp_t rhpsb_susp_step(
        input rhpsb_susp_t cur,
        input logic go_suspend,
        input logic go_resume,
        input logic end_resume
    );
        rhpsb_susp_t nxt;
        nxt = cur;
        // Resume end only counts once the resume has actually begun
        case (cur)
            RHPSB_ACTIVE: begin
                if (go_suspend) begin
                    nxt = RHPSB_SUSPENDED; // R01
                end
            end
            RHPSB_SUSPENDED: begin
                if (go_resume) begin
                    nxt = RHPSB_RESUMING;
                end
            end
            RHPSB_RESUMING: begin
                if (end_resume) begin
                    nxt = RHPSB_ACTIVE; // R14
                end
            end
            default: begin
                nxt = RHPSB_ACTIVE;
            end
        endcase
        return nxt;
    endfunction : rhpsb_susp_step

    // Enable flag step; later terms win, so a hardware disable or a detach has the last word
    function automatic logic rhpsb_enable_step(
        input logic cur,
        input logic set_cmd,
        input logic clr_cmd,
        input logic reset_end,
        input logic attached,
        input logic hw_off
    );
        logic nxt;
        nxt = cur;
        if (set_cmd) begin
            nxt = 1'b1; // R08
        end
        if (clr_cmd) begin
            nxt = 1'b0; // R11
        end
        if (reset_end && attached) begin
            nxt = 1'b1; // R07
        end
        if (hw_off || !attached) begin
            nxt = 1'b0; // R04 R06
        end
        return nxt;
    endfunction : rhpsb_enable_step

    // ==========================================
    // State word, next value and decoded events
    rhpsb_state_t st_r;
    rhpsb_state_t st_nxt;
    rhpsb_if ev ();

    // ==========================================
    // Event decode
    rhpsb_cmd_decode u_dec (
        .wr_strobe(wr_strobe),
        .wr_data(wr_data),
        .line_connected(line_connected),
        .fixed_device(fixed_device),
        .overcurrent(overcurrent),
        .power_off(power_off),
        .babble(babble),
        .enabled_now(st_r.enabled),
        .ev(ev.src)
    );

    // ==========================================
    // Next state; change flags are sticky here and only the reset state clears them
    always_comb begin
        st_nxt = st_r;
        // Attach follows the live line; writes have no path into it
        st_nxt.attach = ev.attach; // R10 R12 R13
        if (ev.attach != st_r.attach || ev.attach_change_pulse) begin
            st_nxt.attach_chg = 1'b1; // R02 R09
        end

        // Enable: set and clear commands, hardware faults win over a set while the port is enabled
        st_nxt.enabled = rhpsb_enable_step(
            st_r.enabled,
            ev.set_enable,
            ev.clr_enable,
            port_reset_done,
            ev.attach,
            ev.hw_disable
        );
        if (ev.hw_disable) begin
            st_nxt.enable_chg = 1'b1; // R05
        end
        if (port_reset_done) begin
            st_nxt.reset_chg = 1'b1; // R07
        end

        // Suspend sub-state and its change flag at the end of resume
        st_nxt.susp = rhpsb_susp_step(
            st_r.susp,
            ev.set_suspend,
            resume_start,
            resume_done
        );
        if (st_r.susp == RHPSB_RESUMING && resume_done) begin
            st_nxt.suspend_chg = 1'b1; // R14
        end

        // Reset end or controller resume state aborts suspend, no change flag
        if (port_reset_done || hc_resume_state) begin
            st_nxt.susp = RHPSB_ACTIVE; // R14
        end
        // Decoded here so the suspended output leaves a flop, not a compare
        st_nxt.suspended = rhpsb_is_suspended(st_nxt.susp); // R03

        // Reset last so it overrides every event of the same cycle
        if (!rst_b) begin
            st_nxt = rhpsb_reset_state(ev.attach); // R15
        end
    end

    // ==========================================
    // State register
    // Single state register; reset handled synchronously in the next-state logic
    always_ff @(posedge mclk) begin
        st_r <= st_nxt;
    end

    // ==========================================
    // Outputs straight from the state flops
    assign port_suspended_flag = st_r.suspended; // R03
    assign port_enabled_flag = st_r.enabled;
    assign attach_flag = st_r.attach;
    assign attach_change_flag = st_r.attach_chg;
    assign enable_change_flag = st_r.enable_chg;
    assign reset_done_change_flag = st_r.reset_chg;
    assign suspend_change_flag = st_r.suspend_chg;
endmodule : rhpsb_port
`default_nettype wire

// [rhpsb_port_asserts.sv]
// Checker for the root hub port state bits
`timescale 1ns/1ps
`default_nettype none
module rhpsb_port_asserts
    import rhpsb_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic wr_strobe,
    input wire logic [rhpsb_pkg::RHPSB_CMD_W-1:0] wr_data,
    input wire logic line_connected,
    input wire logic fixed_device,
    input wire logic overcurrent,
    input wire logic power_off,
    input wire logic babble,
    input wire logic resume_done,
    input wire logic port_reset_done,
    input wire logic hc_resume_state,
    input wire logic port_suspended_flag,
    input wire logic port_enabled_flag,
    input wire logic attach_flag,
    input wire logic attach_change_flag,
    input wire logic enable_change_flag
);
    // ========
    // Shared terms; live needs both line and flag so a fresh detach is excluded
    wire logic bad = overcurrent | power_off | babble;
    wire logic live = line_connected & attach_flag;
    wire logic gone = !line_connected & !attach_flag & !fixed_device;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    chk_attach_track: assert property (1'b1 |=> attach_flag == $past(line_connected | fixed_device))
        else $error("attach mismatch");
    chk_enable_attached: assert property ($rose(port_enabled_flag) |-> attach_flag)
        else $error("enabled while detached");
    chk_enable_cmd: assert property (wr_strobe && wr_data[1] && !wr_data[0] && live && !bad |=> port_enabled_flag)
        else $error("enable lost");
    chk_disable_cmd: assert property (wr_strobe && wr_data[0] && !port_reset_done |=> !port_enabled_flag)
        else $error("disable lost");
    chk_hw_disable: assert property (port_enabled_flag && bad |=> !port_enabled_flag && enable_change_flag)
        else $error("hw disable");
    chk_detached_cmd: assert property (wr_strobe && |wr_data[2:1] && gone |=> attach_change_flag && !port_enabled_flag)
        else $error("detached command");
    chk_suspend_cmd: assert property (wr_strobe && wr_data[2] && live && !resume_done && !port_reset_done
        && !hc_resume_state |=> port_suspended_flag)
        else $error("suspend lost");
    chk_reset_done: assert property (port_reset_done && live && !bad && !wr_strobe
        |=> port_enabled_flag && !port_suspended_flag)
        else $error("reset done");
endmodule : rhpsb_port_asserts
bind rhpsb_port rhpsb_port_asserts chk_i (
    .mclk(mclk),
    .rst_b(rst_b),
    .wr_strobe(wr_strobe),
    .wr_data(wr_data),
    .line_connected(line_connected),
    .fixed_device(fixed_device),
    .overcurrent(overcurrent),
    .power_off(power_off),
    .babble(babble),
    .resume_done(resume_done),
    .port_reset_done(port_reset_done),
    .hc_resume_state(hc_resume_state),
    .port_suspended_flag(port_suspended_flag),
    .port_enabled_flag(port_enabled_flag),
    .attach_flag(attach_flag),
    .attach_change_flag(attach_change_flag),
    .enable_change_flag(enable_change_flag)
);
`default_nettype wire

// [rhpsb_port_tb.sv]
// Testbench for the root hub port state bits
`timescale 1ns/1ps
`default_nettype none
module rhpsb_port_tb;
    import rhpsb_pkg::*;
    logic mclk = 1'b0, rst_b = 1'b0, wr_strobe = 1'b0, plug = 1'b0, fixed_device = 1'b0;
    logic overcurrent = 1'b0, power_off = 1'b0, babble = 1'b0, resume_start = 1'b0;
    logic resume_done = 1'b0, port_reset_done = 1'b0, hc_resume_state = 1'b0;
    logic [RHPSB_CMD_W-1:0] wr_data = 3'h0;
    logic line_connected, port_suspended_flag, port_enabled_flag, attach_flag;
    logic attach_change_flag, enable_change_flag, reset_done_change_flag, suspend_change_flag;
    int n_mismatch = 0, tests_run = 0;
    always #5 mclk = ~mclk;
    rhpsb_dev_model dev (.mclk(mclk), .plug(plug), .line_connected(line_connected));
    rhpsb_port dut (
        .mclk(mclk),
        .rst_b(rst_b),
        .wr_strobe(wr_strobe),
        .wr_data(wr_data),
        .line_connected(line_connected),
        .fixed_device(fixed_device),
        .overcurrent(overcurrent),
        .power_off(power_off),
        .babble(babble),
        .resume_start(resume_start),
        .resume_done(resume_done),
        .port_reset_done(port_reset_done),
        .hc_resume_state(hc_resume_state),
        .port_suspended_flag(port_suspended_flag),
        .port_enabled_flag(port_enabled_flag),
        .attach_flag(attach_flag),
        .attach_change_flag(attach_change_flag),
        .enable_change_flag(enable_change_flag),
        .reset_done_change_flag(reset_done_change_flag),
        .suspend_change_flag(suspend_change_flag)
    );
    // ========
    // Drivers move inputs 1 ns after the edge to stay clear of sampling
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(1);
    endtask : pulse
    task automatic wr(input logic [2:0] d);
        wr_data = d;
        pulse(wr_strobe);
    endtask : wr
    task automatic chk(input logic got, input logic exp, input string m);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    // Commands on an empty port
    task automatic t_detached;
        chk(port_enabled_flag | port_suspended_flag | attach_flag, 1'b0, "reset");
        chk(attach_change_flag | enable_change_flag | reset_done_change_flag | suspend_change_flag, 1'b0, "reset chg");
        wr(3'h6);
        chk(port_enabled_flag | port_suspended_flag, 1'b0, "detached set");
        chk(attach_change_flag, 1'b1, "no change");
        chk(attach_flag, 1'b0, "write attach");
    endtask : t_detached
    // Enable, disable, suspend and the three suspend exits
    task automatic t_enable;
        plug = 1'b1;
        step(3);
        chk(attach_flag, 1'b1, "attach");
        wr(3'h2);
        wr(3'h0);
        chk(port_enabled_flag, 1'b1, "enable");
        wr(3'h3);
        chk(port_enabled_flag, 1'b0, "disable");
        wr(3'h4);
        chk(port_suspended_flag, 1'b1, "suspend");
        pulse(resume_start);
        chk(port_suspended_flag, 1'b1, "resuming");
        pulse(resume_done);
        chk(port_suspended_flag, 1'b0, "resume end");
        chk(suspend_change_flag, 1'b1, "susp change");
        wr(3'h4);
        chk(port_suspended_flag, 1'b1, "resuspend");
        pulse(hc_resume_state);
        chk(port_suspended_flag, 1'b0, "hc resume");
        wr(3'h4);
        chk(port_suspended_flag, 1'b1, "suspend again");
        pulse(port_reset_done);
        chk(port_suspended_flag, 1'b0, "reset susp");
        chk(port_enabled_flag, 1'b1, "reset enable");
        chk(reset_done_change_flag, 1'b1, "reset chg set");
    endtask : t_enable
    // Each hardware cause, then unplug and a fixed device
    task automatic t_hw;
        chk(enable_change_flag, 1'b0, "early change");
        for (int i = 0; i < 3; i++) begin
            wr(3'h2);
            {babble, power_off, overcurrent} = 3'h1 << i;
            wr(3'h2);
            chk(port_enabled_flag, 1'b0, "fault");
            {babble, power_off, overcurrent} = 3'h0;
        end
        chk(enable_change_flag, 1'b1, "en change");
        wr(3'h2);
        plug = 1'b0;
        step(3);
        chk(port_enabled_flag, 1'b0, "unplug");
        chk(attach_flag, 1'b0, "unplug attach");
        fixed_device = 1'b1;
        wr(3'h7);
        chk(attach_flag, 1'b1, "fixed");
    endtask : t_hw
    initial begin
        step(3);
        rst_b = 1'b1;
        t_detached;
        t_enable;
        t_hw;
        test_done;
    end
endmodule : rhpsb_port_tb
`default_nettype wire
